// File: hdl/rscr_pkg.sv
package rscr_pkg;

    // register addresses on the host register port
    localparam logic [7:0] RSCR_SD_ADDR = 8'h4D;
    localparam logic [7:0] RSCR_PANEL_ADDR = 8'h4F;
    localparam logic [7:0] RSCR_GEN_ADDR = 8'h50;

    localparam logic [7:0] RSCR_SD_RESET = 8'h64;
    localparam logic [7:0] RSCR_SW_RESET = 8'h24;

    // writable bits; switch bits 7:6 stay zero
    localparam logic [7:0] RSCR_SD_MASK = 8'hFF;
    localparam logic [7:0] RSCR_SW_MASK = 8'h3F;

    // field positions inside each control register
    localparam int RSCR_STATE_LSB = 0;
    localparam int RSCR_EXIT_LSB = 3;
    localparam int RSCR_VOLT_LSB = 6;

    // state codes; codes with bit 2 clear are reserved or mean do not copy
    localparam logic [2:0] RSCR_CODE_OFF = 3'h4;
    localparam logic [2:0] RSCR_CODE_LOW = 3'h5;

    // voltage select codes of the sd card rail
    localparam logic [1:0] RSCR_VOLT_1V8 = 2'h0;
    localparam logic [1:0] RSCR_VOLT_3V3 = 2'h1;

    // rail count and per rail tables, index 0 sd, 1 panel, 2 general
    localparam int RSCR_NUM_RAILS = 3;
    localparam logic [2:0][7:0] RSCR_ADDRS = {RSCR_GEN_ADDR, RSCR_PANEL_ADDR, RSCR_SD_ADDR};
    localparam logic [2:0][7:0] RSCR_RESETS = {RSCR_SW_RESET, RSCR_SW_RESET, RSCR_SD_RESET};
    localparam logic [2:0][7:0] RSCR_MASKS = {RSCR_SW_MASK, RSCR_SW_MASK, RSCR_SD_MASK};

    // decoded operating state of one rail
    typedef enum logic [1:0] {
        RSCR_OFF = 2'b00,
        RSCR_LOW = 2'b01,
        RSCR_ACTIVE = 2'b10
    } rscr_state_t;

    // host register request, same clock as this block
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rscr_req_t;

    // read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rscr_rsp_t;

    // state code to operating state; reserved codes keep the previous state
    function automatic rscr_state_t rscr_decode(input logic [2:0] code, input rscr_state_t prev);
        rscr_state_t res;
        res = prev;
        case (code)
            RSCR_CODE_OFF: res = RSCR_OFF;
            RSCR_CODE_LOW: res = RSCR_LOW;
            3'h6, 3'h7: res = RSCR_ACTIVE;
            default: res = prev;
        endcase
        return res;
    endfunction : rscr_decode

endpackage : rscr_pkg

// File: hdl/rscr_rail_reg.sv
`timescale 1ns/1ps
module rscr_rail_reg #(
    parameter logic [7:0] RESET_VAL = 8'h24,
    parameter logic [7:0] WR_MASK = 8'h3F
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_exit,
    output logic [7:0] o_value,
    output rscr_pkg::rscr_state_t o_state,
    output logic o_volt_3v3
);
    import rscr_pkg::*;

    localparam rscr_state_t STATE_RESET = rscr_decode(RESET_VAL[2:0], RSCR_OFF);
    localparam logic VOLT_RESET = (RESET_VAL[7:6] == RSCR_VOLT_3V3);

    logic [7:0] value_q;
    logic [7:0] value_d;
    rscr_state_t state_q;
    rscr_state_t state_d;
    logic volt_q;
    logic volt_d;
    logic [2:0] exit_code;

    // next register value: host write, then standby exit copy of the stored exit field into the live field
    always_comb
    begin
        exit_code = value_q[RSCR_EXIT_LSB +: 3];
        value_d = value_q;
        if (i_wr)
        begin
            value_d = i_wdata & WR_MASK;
        end
        // exit copy, codes 4 to 7
        if (i_exit && exit_code[2])
        begin
            value_d[RSCR_STATE_LSB +: 3] = exit_code;
        end
        state_d = rscr_decode(value_d[RSCR_STATE_LSB +: 3], state_q);
        volt_d = volt_q;
        if (value_d[RSCR_VOLT_LSB +: 2] == RSCR_VOLT_1V8)
        begin
            volt_d = 1'b0;
        end
        else if (value_d[RSCR_VOLT_LSB +: 2] == RSCR_VOLT_3V3)
        begin
            volt_d = 1'b1;
        end
    end

    // register storage
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            value_q <= RESET_VAL;
            state_q <= STATE_RESET;
            volt_q <= VOLT_RESET;
        end
        else
        begin
            value_q <= value_d;
            state_q <= state_d;
            volt_q <= volt_d;
        end
    end

    assign o_value = value_q;
    assign o_state = state_q;
    assign o_volt_3v3 = volt_q;

endmodule : rscr_rail_reg

// File: hdl/rscr_top.sv
// Function
// - sd rail register at 0x4D, read/write, resets to 0x64.
// - sd live state bits 2:0: 4 off, 5 low power, 6/7 active.
// - on standby exit, sd exit field 5:3 codes 4-7 copy into live state.
// - sd voltage bits 7:6: 0 selects 1.8 V, 1 selects 3.3 V.
// - panel switch register at 0x4F, read/write, resets to 0x24.
// - panel live state bits 2:0 same codes; bits 7:6 reserved.
// - on standby exit, panel exit field 5:3 codes 4-7 copy to live state.
// - general switch register at 0x50, read/write, resets to 0x24.
// - general switch: live bits 2:0, exit bits 5:3, bits 7:6 reserved.
`timescale 1ns/1ps
module rscr_top (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input rscr_pkg::rscr_req_t I_REG_REQ,
    input wire logic I_STANDBY_EXIT_PIN,
    output rscr_pkg::rscr_rsp_t O_REG_RSP,
    output rscr_pkg::rscr_state_t O_SD_RAIL_STATE,
    output logic O_SD_RAIL_VOLT_3V3,
    output rscr_pkg::rscr_state_t O_PANEL_SWITCH_STATE,
    output rscr_pkg::rscr_state_t O_GENERAL_SWITCH_STATE
);
    import rscr_pkg::*;

    logic exit_sync1_q;
    logic exit_sync1_d;
    logic exit_sync2_q;
    logic exit_sync2_d;
    logic exit_prev_q;
    logic exit_prev_d;
    logic exit_pulse;
    logic [RSCR_NUM_RAILS-1:0] wr_hit;
    logic [RSCR_NUM_RAILS-1:0][7:0] value;
    rscr_state_t [RSCR_NUM_RAILS-1:0] state;
    logic [RSCR_NUM_RAILS-1:0] volt;
    rscr_rsp_t rsp_q;
    rscr_rsp_t rsp_d;

    // standby exit pin: two flops, then rising edge detect
    always_comb
    begin
        exit_sync1_d = I_STANDBY_EXIT_PIN;
        exit_sync2_d = exit_sync1_q;
        exit_prev_d = exit_sync2_q;
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            exit_sync1_q <= 1'b0;
            exit_sync2_q <= 1'b0;
            exit_prev_q <= 1'b0;
        end
        else
        begin
            exit_sync1_q <= exit_sync1_d;
            exit_sync2_q <= exit_sync2_d;
            exit_prev_q <= exit_prev_d;
        end
    end

    assign exit_pulse = exit_sync2_q & ~exit_prev_q;

    // one control register per rail, decoded from the host address
    for (genvar g = 0; g < RSCR_NUM_RAILS; g++)
    begin : g_rail
        assign wr_hit[g] = I_REG_REQ.wr && (I_REG_REQ.addr == RSCR_ADDRS[g]);

        rscr_rail_reg #(
            .RESET_VAL(RSCR_RESETS[g]),
            .WR_MASK(RSCR_MASKS[g])
        ) u_reg (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_wr(wr_hit[g]),
            .i_wdata(I_REG_REQ.wdata),
            .i_exit(exit_pulse),
            .o_value(value[g]),
            .o_state(state[g]),
            .o_volt_3v3(volt[g])
        );
    end

    // read answer one cycle after the request; unmapped addresses read zero
    always_comb
    begin
        rsp_d.valid = I_REG_REQ.rd;
        rsp_d.data = 8'h00;
        for (int k = 0; k < RSCR_NUM_RAILS; k++)
        begin
            if (I_REG_REQ.rd && (I_REG_REQ.addr == RSCR_ADDRS[k]))
            begin
                rsp_d.data = value[k];
            end
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // outputs, all from flops
    assign O_REG_RSP = rsp_q;
    assign O_SD_RAIL_STATE = state[0];
    assign O_SD_RAIL_VOLT_3V3 = volt[0];
    assign O_PANEL_SWITCH_STATE = state[1];
    assign O_GENERAL_SWITCH_STATE = state[2];

    // checks on this block's own behaviour
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    a_sd_reset_val: assert property ($past(I_RST) |-> value[0] == RSCR_SD_RESET)
        else $error("sd register not at reset value after reset");

    a_sd_write_read: assert property (
        wr_hit[0] && !exit_pulse ##1 I_REG_REQ.rd && !I_REG_REQ.wr && !exit_pulse
        && I_REG_REQ.addr == RSCR_SD_ADDR |=> O_REG_RSP.valid
        && O_REG_RSP.data == $past(I_REG_REQ.wdata, 2))
        else $error("sd register read does not return written value");

    a_sd_state_map: assert property (value[0][2] |-> O_SD_RAIL_STATE ==
        (value[0][1] ? RSCR_ACTIVE : (value[0][0] ? RSCR_LOW : RSCR_OFF)))
        else $error("sd rail state does not follow state code");

    a_sd_exit_copy: assert property (exit_pulse && value[0][5] && !wr_hit[0]
        |=> value[0][2:0] == $past(value[0][5:3]))
        else $error("sd exit field not copied on standby exit");

    a_exit_pin_edge: assert property ($rose(I_STANDBY_EXIT_PIN) ##1 I_STANDBY_EXIT_PIN
        |-> ##1 exit_pulse)
        else $error("standby exit edge not seen two cycles later");

    a_sd_volt_sel: assert property (value[0][7:6] == RSCR_VOLT_1V8 && !$past(I_RST)
        |-> !O_SD_RAIL_VOLT_3V3 or value[0][7:6] != RSCR_VOLT_1V8)
        else $error("sd voltage not 1.8 V for code 0");

    a_sd_volt_3v3: assert property (value[0][7:6] == RSCR_VOLT_3V3 |-> O_SD_RAIL_VOLT_3V3)
        else $error("sd voltage not 3.3 V for code 1");

    a_sd_volt_hold: assert property (value[0][7] && !$past(I_RST)
        |-> $stable(O_SD_RAIL_VOLT_3V3))
        else $error("sd voltage acted on reserved code");

    a_panel_reset_val: assert property ($past(I_RST) |-> value[1] == RSCR_SW_RESET)
        else $error("panel register not at reset value after reset");

    a_panel_reserved: assert property (wr_hit[1] |=> value[1][7:6] == 2'h0
        && value[1][5:3] == $past(I_REG_REQ.wdata[5:3]))
        else $error("panel reserved bits not zero after write");

    a_panel_state_map: assert property (value[1][2] |-> O_PANEL_SWITCH_STATE ==
        (value[1][1] ? RSCR_ACTIVE : (value[1][0] ? RSCR_LOW : RSCR_OFF)))
        else $error("panel state does not follow state code");

    a_panel_nocopy: assert property (exit_pulse && !value[1][5] && !wr_hit[1]
        |=> $stable(value[1]) && $stable(O_PANEL_SWITCH_STATE))
        else $error("panel changed on do-not-copy exit code");

    a_panel_exit_copy: assert property (exit_pulse && value[1][5] && !wr_hit[1]
        |=> value[1][2:0] == $past(value[1][5:3]))
        else $error("panel exit field not copied on standby exit");

    a_panel_code_hold: assert property (!value[1][2] && !$past(I_RST)
        |-> $stable(O_PANEL_SWITCH_STATE))
        else $error("panel state acted on reserved code");

    a_gen_reset_val: assert property ($past(I_RST) |-> value[2] == RSCR_SW_RESET)
        else $error("general register not at reset value after reset");

    a_gen_exit_copy: assert property (exit_pulse && value[2][5] && !wr_hit[2]
        |=> value[2][2:0] == $past(value[2][5:3]) && value[2][7:6] == 2'h0)
        else $error("general exit field not copied on standby exit");

    a_gen_nocopy: assert property (exit_pulse && !value[2][5] && !wr_hit[2]
        |=> $stable(value[2]) && $stable(O_GENERAL_SWITCH_STATE))
        else $error("general changed on do-not-copy exit code");

    a_gen_reserved: assert property (wr_hit[2] |=> value[2][7:6] == 2'h0
        && value[2][5:3] == $past(I_REG_REQ.wdata[5:3]))
        else $error("general reserved bits not zero after write");

    a_gen_state_map: assert property (value[2][2] |-> O_GENERAL_SWITCH_STATE ==
        (value[2][1] ? RSCR_ACTIVE : (value[2][0] ? RSCR_LOW : RSCR_OFF)))
        else $error("general state does not follow state code");

    a_reserved_hold: assert property (!value[0][2] && !$past(I_RST)
        |-> $stable(O_SD_RAIL_STATE))
        else $error("sd rail state acted on reserved code");

    a_unmapped_zero: assert property (I_REG_REQ.rd && I_REG_REQ.addr == 8'h4E
        |=> O_REG_RSP.valid && O_REG_RSP.data == 8'h00)
        else $error("unmapped read not zero");

    a_read_answer: assert property (!$past(I_RST)
        |-> O_REG_RSP.valid == $past(I_REG_REQ.rd))
        else $error("read answer not one cycle after request");

    c_sd_exit: cover property (exit_pulse && value[0][5]
        ##1 O_SD_RAIL_STATE != $past(O_SD_RAIL_STATE));
    c_sd_to_1v8: cover property (O_SD_RAIL_VOLT_3V3 ##1 !O_SD_RAIL_VOLT_3V3);
    c_panel_read: cover property (I_REG_REQ.rd && I_REG_REQ.addr == RSCR_PANEL_ADDR);
    c_gen_active: cover property (O_GENERAL_SWITCH_STATE == RSCR_ACTIVE);
    c_gen_exit: cover property (exit_pulse && value[2][5] && !wr_hit[2]);

endmodule : rscr_top

// File: verification/rscr_host_model.sv
`timescale 1ns/1ps
module rscr_host_model (
    input wire logic i_clk,
    input rscr_pkg::rscr_rsp_t i_rsp,
    output rscr_pkg::rscr_req_t o_req
);
    import rscr_pkg::*;

    // idle request until the first transfer
    initial o_req = '0;

    // one write, held up to its taking edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1;
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk) #1;
        o_req = '0;
    endtask : write

    // one read; answer is valid right after the taking edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk) #1;
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk) #1;
        o_req = '0;
        d = (i_rsp.valid === 1'b1) ? i_rsp.data : 8'hXX;
    endtask : read

    // write then read of one place on back-to-back edges
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk) #1;
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk) #1;
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk) #1;
        o_req = '0;
        q = (i_rsp.valid === 1'b1) ? i_rsp.data : 8'hXX;
    endtask : write_read

    task automatic sd_bringup();
        write(RSCR_SD_ADDR, 8'h46); // on at 3.3 V
        write(RSCR_SD_ADDR, 8'h44); // off
        write(RSCR_SD_ADDR, 8'h04); // 1.8 V while off
        write(RSCR_SD_ADDR, 8'h06); // back on
    endtask : sd_bringup
endmodule : rscr_host_model

// File: verification/rscr_top_test.sv
`timescale 1ns/1ps
module rscr_top_test;
    import rscr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b0;
    rscr_req_t req;
    rscr_rsp_t rsp;
    rscr_state_t sd_st, pn_st, gp_st;
    logic volt;
    logic [7:0] rd;
    logic [7:0] wv;
    logic [1:0] exp_st;
    int bad_count = 0;
    int cmp_count = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    rscr_top u_dut (.I_MCLK(clk), .I_RST(rst), .I_REG_REQ(req), .I_STANDBY_EXIT_PIN(pin),
        .O_REG_RSP(rsp), .O_SD_RAIL_STATE(sd_st), .O_SD_RAIL_VOLT_3V3(volt),
        .O_PANEL_SWITCH_STATE(pn_st), .O_GENERAL_SWITCH_STATE(gp_st));
    rscr_host_model u_host (.i_clk(clk), .i_rsp(rsp), .o_req(req));

    // compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // expected state: 4 off, 5 low, 6/7 active, others keep
    function automatic logic [1:0] st_of(input logic [2:0] c, input logic [1:0] prev);
        return c[2] ? (c[1] ? 2'h2 : {1'b0, c[0]}) : prev;
    endfunction : st_of

    // state output of rail i, widened
    function automatic logic [7:0] st_out(input int i);
        return (i == 0) ? {6'h00, sd_st} : (i == 1) ? {6'h00, pn_st} : {6'h00, gp_st};
    endfunction : st_out

    // power-up values and states
    task automatic t_reset();
        for (int i = 0; i < 3; i++)
        begin
            u_host.read(RSCR_ADDRS[i], rd);
            chk("reset value", rd, RSCR_RESETS[i]);
            chk("reset state", st_out(i), 8'h00);
        end
        chk("reset volt", {7'h00, volt}, 8'h01);
    endtask : t_reset

    // every state code on every rail, reserved bits set on write
    task automatic t_codes();
        for (int i = 0; i < 3; i++)
        begin
            exp_st = 2'h0;
            for (int k = 0; k < 8; k++)
            begin
                wv = 8'hC0 | {5'h00, k[2:0] ^ 3'h6};
                u_host.write(RSCR_ADDRS[i], wv);
                exp_st = st_of(wv[2:0], exp_st);
                chk("state code", st_out(i), {6'h00, exp_st});
                u_host.read(RSCR_ADDRS[i], rd);
                chk("readback", rd, wv & RSCR_MASKS[i]);
            end
        end
        chk("reserved volt", {7'h00, volt}, 8'h01);
    endtask : t_codes

    // voltage select and unmapped place
    task automatic t_volt();
        u_host.sd_bringup();
        chk("volt 1v8", {7'h00, volt}, 8'h00);
        chk("sd on", {6'h00, sd_st}, 8'h02);
        u_host.write(8'h4E, 8'hFF);
        u_host.read(8'h4E, rd);
        chk("unmapped", rd, 8'h00);
        u_host.read(RSCR_SD_ADDR, rd);
        chk("sd kept", rd, 8'h06);
        u_host.write_read(RSCR_SD_ADDR, 8'h45, rd);
        chk("back to back", rd, 8'h45);
        chk("sd low", {6'h00, sd_st}, 8'h01);
        chk("volt 3v3", {7'h00, volt}, 8'h01);
    endtask : t_volt

    // raise the exit pin, leave it high, and wait for the copy
    task automatic pin_rise();
        @(posedge clk) #1 pin = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : pin_rise

    // standby exit copy, do-not-copy, one copy per rising edge
    task automatic t_exit();
        u_host.write(RSCR_SD_ADDR, 8'h6C);
        u_host.write(RSCR_PANEL_ADDR, 8'h3C);
        u_host.write(RSCR_GEN_ADDR, 8'h15);
        pin_rise();
        chk("sd exit", {6'h00, sd_st}, 8'h01);
        chk("panel exit", {6'h00, pn_st}, 8'h02);
        chk("gen no copy", {6'h00, gp_st}, 8'h01);
        u_host.read(RSCR_SD_ADDR, rd);
        chk("sd copied", rd, 8'h6D);
        u_host.write(RSCR_PANEL_ADDR, 8'h3C);
        u_host.write(RSCR_GEN_ADDR, 8'h35);
        repeat (6) @(posedge clk);
        chk("held pin", {6'h00, pn_st}, 8'h00);
        chk("held pin gen", {6'h00, gp_st}, 8'h01);
        @(posedge clk) #1 pin = 1'b0;
        repeat (3) @(posedge clk);
        pin_rise();
        chk("second edge", {6'h00, pn_st}, 8'h02);
        chk("gen exit", {6'h00, gp_st}, 8'h02);
        u_host.read(RSCR_GEN_ADDR, rd);
        chk("gen copied", rd, 8'h36);
        // panel exit code 2 must not be copied on the third edge
        u_host.write(RSCR_PANEL_ADDR, 8'h16);
        @(posedge clk) #1 pin = 1'b0;
        repeat (3) @(posedge clk);
        pin_rise();
        chk("panel no copy", {6'h00, pn_st}, 8'h02);
        u_host.read(RSCR_PANEL_ADDR, rd);
        chk("panel kept", rd, 8'h16);
    endtask : t_exit

    // verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // main sequence after two reset cycles
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_codes();
        t_volt();
        t_exit();
        conclude();
    end

    // watchdog, far beyond the roughly 170 cycles needed
    initial
    begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule : rscr_top_test
